// *** hw/udie_ctrl.sv ***
// device interrupt enable, event flags, frame count and address filter for one engine
// Operation
// - vbus edges raise flag, bit 15 enables
// - vbus/id bits exist only in first engine
// - id pin edges raise flag, bit 14 enables
// - no sof/eop in period raises timeout
// - frame counts timeouts between sof/eop
// - bit 9 gates sof/eop received interrupt
// - bit 8 gates bus reset interrupt
// - bits 7..0 gate endpoint done interrupts
// - done on ack stall timeout exceptions
// - nak also done when nak enable set
// - device address resets to zero
// - respond only to matching packet address
// - address seven bits, write only
// - address register at c08e or c0ae
// - status register at c090 or c0b0
// - enable register at c08c/c0ac, resets zero
// - write one clears pending flag
`timescale 1ns/1ns
module udie_ctrl
  import udie_pkg::*;
#(
  parameter bit SECOND_ENGINE = 1'b0
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input udie_req_s req,
  output logic [15:0] rdata,
  output logic hit,
  // otg pins of the otg-capable port, asynchronous
  input wire logic vbus_above_thresh,
  input wire logic otg_id_pin,
  // usb engine events, same clock
  input wire logic sof_eop_rx,
  input wire logic bus_reset_det,
  input wire logic [15:0] sof_eop_limit,
  input udie_ep_evt_s [UDIE_NUM_EP-1:0] endpoint_x_evt,
  // token address check
  input wire logic [6:0] token_addr,
  output logic addr_match,
  // status out
  output logic [15:0] frame_count,
  output logic [6:0] device_address,
  output logic irq
);
  // ----------------------------------------
  // register decode
  // ----------------------------------------
  localparam logic [15:0] IMPL = SECOND_ENGINE ? UDIE_IMPL_SECOND : UDIE_IMPL_FIRST;
  localparam logic [15:0] A_MASK = SECOND_ENGINE ? UDIE_MASK_ADDR_SECOND : UDIE_MASK_ADDR_FIRST;
  localparam logic [15:0] A_ADDR = SECOND_ENGINE ? UDIE_ADDR_ADDR_SECOND : UDIE_ADDR_ADDR_FIRST;
  localparam logic [15:0] A_FLAG = SECOND_ENGINE ? UDIE_FLAG_ADDR_SECOND : UDIE_FLAG_ADDR_FIRST;

  logic sel_mask;
  logic sel_addr;
  logic sel_flag;
  assign sel_mask = req.addr == A_MASK;
  assign sel_addr = req.addr == A_ADDR;
  assign sel_flag = req.addr == A_FLAG;
  assign hit = sel_mask | sel_addr | sel_flag;

  // ----------------------------------------
  // event sources
  // ----------------------------------------
  logic vbus_edge;
  logic id_edge;
  logic [UDIE_NUM_EP-1:0] ep_done;

  udie_edge_sync u_vbus (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(vbus_above_thresh),
    .edge_pulse(vbus_edge)
  );

  udie_edge_sync u_id (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(otg_id_pin),
    .edge_pulse(id_edge)
  );

  for (genvar g = 0; g < UDIE_NUM_EP; g++) begin : g_ep
    udie_ep_done u_done (
      .evt(endpoint_x_evt[g]),
      .done(ep_done[g])
    );
  end

  // ----------------------------------------
  // sof/eop timeout watchdog and frame count
  // ----------------------------------------
  logic [15:0] sof_timer;
  logic [15:0] next_sof_timer;
  logic [15:0] next_frame_count;
  logic sof_timeout;

  always_comb begin
    sof_timeout = 1'b0;
    next_sof_timer = sof_timer + 16'h0001;
    next_frame_count = frame_count;
    if (sof_eop_rx) begin
      next_sof_timer = 16'h0000;
      next_frame_count = UDIE_FRAME_RST;
    end else if (sof_timer >= sof_eop_limit) begin
      // restart so repeated misses each count once
      sof_timeout = 1'b1;
      next_sof_timer = 16'h0000;
      next_frame_count = frame_count + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sof_timer <= 16'h0000;
      frame_count <= UDIE_FRAME_RST;
    end else begin
      sof_timer <= next_sof_timer;
      frame_count <= next_frame_count;
    end
  end

  // ----------------------------------------
  // enable mask, flags and address
  // ----------------------------------------
  logic [15:0] mask;
  logic [15:0] flags;
  logic [15:0] next_mask;
  logic [15:0] next_flags;
  logic [6:0] next_device_address;
  logic [15:0] evt_set;

  always_comb begin
    evt_set = 16'h0000;
    evt_set[UDIE_BIT_VBUS] = vbus_edge;
    evt_set[UDIE_BIT_ID] = id_edge;
    evt_set[UDIE_BIT_TIMEOUT] = sof_timeout;
    evt_set[UDIE_BIT_SOF] = sof_eop_rx;
    evt_set[UDIE_BIT_RESET] = bus_reset_det;
    evt_set[UDIE_NUM_EP-1:0] = ep_done;
    evt_set = evt_set & IMPL;
  end

  always_comb begin
    next_mask = mask;
    next_flags = flags;
    next_device_address = device_address;
    if (req.wr && sel_mask) begin
      next_mask = req.wdata & IMPL;
    end
    if (req.wr && sel_addr) begin
      // reserved upper bits are dropped, software keeps them zero
      next_device_address = req.wdata[UDIE_ADDR_W-1:0];
    end
    if (req.wr && sel_flag) begin
      next_flags = flags & ~req.wdata;
    end
    // set wins over a clear in the same cycle
    next_flags = next_flags | evt_set;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask <= UDIE_MASK_RST;
      flags <= UDIE_FLAG_RST;
      device_address <= UDIE_DEVADDR_RST;
    end else begin
      mask <= next_mask;
      flags <= next_flags;
      device_address <= next_device_address;
    end
  end

  // ----------------------------------------
  // read mux, irq and address filter
  // ----------------------------------------
  always_comb begin
    rdata = 16'h0000;
    if (req.rd && sel_mask) begin
      rdata = mask;
    end else if (req.rd && sel_flag) begin
      rdata = flags;
    end
    // address register is write only and reads zero
  end

  // bits 15/14 (first engine only), 11, 9, 8 and 7..0 reach irq through the enable mask
  assign irq = |(flags & mask);
  assign addr_match = token_addr == device_address;
endmodule // udie_ctrl

// *** hw/udie_pkg.sv ***
// package: register map, field positions and carriers for the device interrupt block
package udie_pkg;
  // register byte addresses
  localparam logic [15:0] UDIE_MASK_ADDR_FIRST = 16'hc08c;
  localparam logic [15:0] UDIE_ADDR_ADDR_FIRST = 16'hc08e;
  localparam logic [15:0] UDIE_FLAG_ADDR_FIRST = 16'hc090;
  localparam logic [15:0] UDIE_MASK_ADDR_SECOND = 16'hc0ac;
  localparam logic [15:0] UDIE_ADDR_ADDR_SECOND = 16'hc0ae;
  localparam logic [15:0] UDIE_FLAG_ADDR_SECOND = 16'hc0b0;
  // field positions
  localparam int UDIE_BIT_VBUS = 15;
  localparam int UDIE_BIT_ID = 14;
  localparam int UDIE_BIT_TIMEOUT = 11;
  localparam int UDIE_BIT_SOF = 9;
  localparam int UDIE_BIT_RESET = 8;
  localparam int UDIE_NUM_EP = 8;
  localparam int UDIE_ADDR_W = 7;
  // implemented-bit masks per engine
  localparam logic [15:0] UDIE_IMPL_FIRST = 16'hcbff;
  localparam logic [15:0] UDIE_IMPL_SECOND = 16'h0bff;
  // reset values
  localparam logic [15:0] UDIE_MASK_RST = 16'h0000;
  localparam logic [15:0] UDIE_FLAG_RST = 16'h0000;
  localparam logic [6:0] UDIE_DEVADDR_RST = 7'h00;
  localparam logic [15:0] UDIE_FRAME_RST = 16'h0000;
  localparam logic [15:0] UDIE_SOF_LIMIT_RST = 16'h2ee0;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } udie_req_s;

  // endpoint transaction outcome, one per endpoint
  typedef struct packed {
    logic ack;
    logic stall;
    logic timeout;
    logic in_exc;
    logic out_exc;
    logic nak;
    logic nak_ie;
  } udie_ep_evt_s;
endpackage

// *** hw/udie_edge_sync.sv ***
// two-flop synchroniser with both-edge pulse
`timescale 1ns/1ns
module udie_edge_sync
  import udie_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // asynchronous level in, edge pulse out
  input wire logic pin_in,
  output logic edge_pulse
);
  logic meta;
  logic sync;
  logic last;
  logic next_meta;
  logic next_sync;
  logic next_last;

  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    next_last = sync;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
    end
  end

  // only the second flop and its delayed copy feed the compare
  assign edge_pulse = sync ^ last;
endmodule // udie_edge_sync

// *** hw/udie_ep_done.sv ***
// endpoint transaction-done event combiner
`timescale 1ns/1ns
module udie_ep_done
  import udie_pkg::*;
(
  // one endpoint's outcome strobes
  input udie_ep_evt_s evt,
  // single-cycle done event
  output logic done
);
  always_comb begin
    done = evt.ack | evt.stall | evt.timeout | evt.in_exc | evt.out_exc;
    if (evt.nak && evt.nak_ie) begin
      done = 1'b1;
    end
  end
endmodule // udie_ep_done

// *** tb/udie_host_model.sv ***
// host side model: bus reset on start, one sof/eop after PERIOD
`timescale 1ns/1ns
module udie_host_model #(
  parameter int PERIOD = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control in, bus events out
  input wire logic run,
  output logic sof_eop_rx,
  output logic bus_reset_det
);
  int cnt;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
    end else begin
      cnt <= run ? cnt + 1 : 0;
    end
  end
  // single sof only, so the timeout path is exercised after it
  assign bus_reset_det = run && cnt == 1;
  assign sof_eop_rx = run && cnt == PERIOD;
endmodule // udie_host_model

// *** tb/udie_ctrl_assertions.sv ***
// port checks for the first engine
`timescale 1ns/1ns
module udie_ctrl_assertions
  import udie_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // watched ports
  input udie_req_s req,
  input wire logic [15:0] rdata,
  input wire logic hit,
  input wire logic [6:0] token_addr,
  input wire logic addr_match,
  input wire logic [6:0] device_address,
  input wire logic sof_eop_rx,
  input wire logic [15:0] frame_count,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_mask_off;
    req.wr && req.addr == UDIE_MASK_ADDR_FIRST && req.wdata == 16'h0000;
  endsequence
  AST_MATCH: assert property (addr_match == (token_addr == device_address))
    else $error("address match wrong");
  AST_HIT: assert property (hit == (req.addr inside {16'hc08c, 16'hc08e, 16'hc090}))
    else $error("decode wrong");
  AST_ADDR_WR: assert property (req.wr && req.addr == UDIE_ADDR_ADDR_FIRST |=>
    device_address == $past(req.wdata[6:0])) else $error("address not stored");
  AST_ADDR_RD: assert property (req.rd && req.addr == UDIE_ADDR_ADDR_FIRST |-> rdata == 16'h0000)
    else $error("address readable");
  AST_MASK_RD: assert property (req.rd && req.addr == UDIE_MASK_ADDR_FIRST |->
    (rdata & ~UDIE_IMPL_FIRST) == 16'h0000) else $error("reserved mask bit set");
  AST_MISS: assert property (!hit |-> rdata == 16'h0000) else $error("unmapped read data");
  AST_IRQ_OFF: assert property (s_mask_off |=> !irq) else $error("irq with mask clear");
  AST_SOF: assert property (sof_eop_rx |=> frame_count == 16'h0000) else $error("frame not cleared");
  AST_FRM: assert property (!$past(sof_eop_rx) && $changed(frame_count) |->
    frame_count == $past(frame_count) + 16'h0001) else $error("frame step wrong");
endmodule // udie_ctrl_assertions

// *** tb/udie_ctrl_tb.sv ***
// bench for the first engine of the device interrupt block
`timescale 1ns/1ns
module udie_ctrl_tb;
  import udie_pkg::*;
  localparam int LIM = 20;
  logic core_clk = 0;
  logic rst_b = 0;
  udie_req_s req = '0;
  logic vbus = 0;
  logic id_pin = 0;
  logic run = 0;
  logic [15:0] limit = 16'hffff;
  udie_ep_evt_s [UDIE_NUM_EP-1:0] ep = '0;
  logic [6:0] tok = 7'h00;
  logic [15:0] rdata, frame_count;
  logic hit, addr_match, irq, sof, brst;
  logic [6:0] dev_addr;
  logic [6:0] kind [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h03, 7'h02, 7'h40};
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 core_clk = ~core_clk;
  udie_host_model #(.PERIOD(10)) host (.core_clk, .rst_b, .run, .sof_eop_rx(sof), .bus_reset_det(brst));
  udie_ctrl dut (.core_clk, .rst_b, .req, .rdata, .hit, .vbus_above_thresh(vbus), .otg_id_pin(id_pin),
    .sof_eop_rx(sof), .bus_reset_det(brst), .sof_eop_limit(limit), .endpoint_x_evt(ep),
    .token_addr(tok), .addr_match, .frame_count, .device_address(dev_addr), .irq);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    req = {1'b1, 1'b0, a, d};
    @(negedge core_clk);
    req = '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge core_clk);
    req = {1'b0, 1'b1, a, 16'h0000};
    #1;
    chk(rdata, exp);
    @(negedge core_clk);
    req = '0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1;
    rd(UDIE_MASK_ADDR_FIRST, 16'h0000);
    rd(UDIE_FLAG_ADDR_FIRST, 16'h0000);
    chk(16'(dev_addr), 16'h0000);
    wr(UDIE_MASK_ADDR_FIRST, 16'hffff);
    rd(UDIE_MASK_ADDR_FIRST, UDIE_IMPL_FIRST);
    rd(16'hc092, 16'h0000);
    wr(UDIE_ADDR_ADDR_FIRST, 16'h002a);
    chk(16'(dev_addr), 16'h002a);
    rd(UDIE_ADDR_ADDR_FIRST, 16'h0000);
    tok = 7'h2a;
    #1 chk(16'(addr_match), 16'h0001);
    tok = 7'h2b;
    #1 chk(16'(addr_match), 16'h0000);
    foreach (kind[k]) begin
      @(negedge core_clk);
      ep[k] = kind[k];
      @(negedge core_clk);
      ep[k] = '0;
      rd(UDIE_FLAG_ADDR_FIRST, (k == 6) ? 16'h0000 : 16'h0001 << k);
      chk(16'(irq), (k == 6) ? 16'h0000 : 16'h0001);
      wr(UDIE_FLAG_ADDR_FIRST, 16'hffff);
    end
    rd(UDIE_FLAG_ADDR_FIRST, 16'h0000);
    limit = 16'(LIM);
    run = 1;
    repeat (62) @(negedge core_clk);
    chk(frame_count, 16'h0002);
    rd(UDIE_FLAG_ADDR_FIRST, 16'h0b00);
    // each enable bit alone gates its own pending flag only
    wr(UDIE_MASK_ADDR_FIRST, 16'h0800);
    chk(16'(irq), 16'h0001);
    wr(UDIE_MASK_ADDR_FIRST, 16'h0200);
    chk(16'(irq), 16'h0001);
    wr(UDIE_MASK_ADDR_FIRST, 16'h0100);
    chk(16'(irq), 16'h0001);
    wr(UDIE_MASK_ADDR_FIRST, 16'h00ff);
    chk(16'(irq), 16'h0000);
    wr(UDIE_MASK_ADDR_FIRST, 16'h0000);
    chk(16'(irq), 16'h0000);
    limit = 16'hffff;
    wr(UDIE_FLAG_ADDR_FIRST, 16'hffff);
    wr(UDIE_MASK_ADDR_FIRST, 16'h8000);
    vbus = 1;
    repeat (5) @(negedge core_clk);
    rd(UDIE_FLAG_ADDR_FIRST, 16'h8000);
    chk(16'(irq), 16'h0001);
    wr(UDIE_MASK_ADDR_FIRST, 16'h4000);
    chk(16'(irq), 16'h0000);
    id_pin = 1;
    repeat (5) @(negedge core_clk);
    rd(UDIE_FLAG_ADDR_FIRST, 16'hc000);
    chk(16'(irq), 16'h0001);
    wr(UDIE_FLAG_ADDR_FIRST, 16'hffff);
    vbus = 0;
    repeat (5) @(negedge core_clk);
    rd(UDIE_FLAG_ADDR_FIRST, 16'h8000);
    tally_and_finish();
  end
endmodule // udie_ctrl_tb
bind udie_ctrl udie_ctrl_assertions chk_i (.core_clk, .rst_b, .req, .rdata, .hit, .token_addr, .addr_match,
  .device_address, .sof_eop_rx, .frame_count, .irq);
